/* File: verilog/isl_defs.vh */
// Constants for the isolated serial line control block
`ifndef ISL_DEFS_VH
`define ISL_DEFS_VH
`define ISL_ADR_RBR 3'h0
`define ISL_ADR_IER 3'h1
`define ISL_ADR_LCR 3'h2
`define ISL_ADR_DLL 3'h3
`define ISL_ADR_DLM 3'h4
`define ISL_ADR_STAT 3'h5
`define ISL_ADR_IST 3'h6
`define ISL_ADR_IMSK 3'h7
`define ISL_MODE_232 2'h0
`define ISL_MODE_422 2'h1
`define ISL_MODE_485 2'h2
`define ISL_FIFO_DEPTH 128
`define ISL_FIFO_AW 7
`define ISL_REF_DIV 4
`define ISL_REF_DIV1 1
`define ISL_OVS 16
`define ISL_DIV_RST 16'h0030
`define ISL_LCR_RST 8'h03
`define ISL_IST_RX 0
`define ISL_IST_TXE 1
`define ISL_IST_OVR 2
`define ISL_IST_FERR 3
`endif

/* File: verilog/isl_serial_line.v */
// Serial port with line mode, multidrop driver enable, echo and prescale control
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "isl_defs.vh"

module isl_serial_line (
   input wire clk_sys,
   input wire rst_b,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire irq,
   input wire [1:0] interface_select_switch,
   input wire auto_driver_enable_sel,
   input wire rts_driver_enable_sel,
   input wire prescale_quarter_sel,
   input wire prescale_unity_sel,
   input wire noEchoSel,
   input wire refClkTick,
   input wire rxLine,
   input wire ctsLine,
   output reg txData,
   output wire txOe_b,
   output wire rtsLine,
   output wire [1:0] lineMode
);
   reg [7:0] ier;
   reg [7:0] lcr;
   reg [15:0] divisor;
   reg [7:0] mcr;
   reg [3:0] istat;
   reg [3:0] imask;
   reg [7:0] txMem [0:127];
   reg [7:0] rxMem [0:127];
   reg [7:0] txWp, txRp, rxWp, rxRp;
   reg [1:0] preCnt;
   reg [15:0] divCnt;
   reg baudTick;
   reg [3:0] txOvs;
   reg [3:0] txBit;
   reg [9:0] txShift;
   reg txBusy;
   reg [3:0] rxOvs;
   reg [3:0] rxBit;
   reg [7:0] rxShift;
   reg rxBusy;
   reg rxSync;
   reg autoEn;
   wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wbWr = wbReq & wb_we_i & wb_sel_i[0];
   wire wbRd = wbReq & ~wb_we_i;
   wire [2:0] regIdx = wb_adr_i[4:2];
   wire txFull = (txWp - txRp) == 8'h80;
   wire txEmpty = txWp == txRp;
   wire rxFull = (rxWp - rxRp) == 8'h80;
   wire rxEmpty = rxWp == rxRp;
   wire is485 = interface_select_switch == `ISL_MODE_485;
   wire dlab = lcr[7];
   wire [3:0] dataBits = {2'h0, lcr[1:0]} + 4'h5;
   wire [3:0] stopBits = lcr[2] ? 4'h2 : 4'h1;
   wire [3:0] frameLen = 4'h1 + dataBits + {3'h0, lcr[3]} + stopBits;
   // Short formats leave the high data bits unused on both paths
   wire [3:0] padBits = 4'h8 - dataBits;
   wire [7:0] dataMask = 8'hff >> padBits;
   wire parityBit = ^(txMem[txRp[6:0]] & dataMask) ^ ~lcr[4];
   // Conflicting prescale switches fall back to the standard rates
   wire unityRate = prescale_unity_sel & ~prescale_quarter_sel;
   // Unity prescale passes every reference tick
   wire preTick = refClkTick & (unityRate | preCnt == 2'h3);
   reg driverOn;
   always @*
   begin
      // Switch outside 485 hands full-time drive; otherwise pick one source
      if (!is485)
         driverOn = 1'b1;
      else if (auto_driver_enable_sel & ~rts_driver_enable_sel)
         driverOn = autoEn;
      else if (rts_driver_enable_sel & ~auto_driver_enable_sel)
         driverOn = mcr[1];
      else
         driverOn = 1'b0;
   end
   assign txOe_b = ~driverOn;
   assign rtsLine = ~mcr[1];
   assign lineMode = interface_select_switch;
   // Own transmission would loop back through the tied pair; gate it in 485 no-echo
   wire rxGate = is485 & noEchoSel & driverOn;
   wire rxIn = rxGate ? 1'b1 : rxLine;
   // Word is stored at the stop-bit sample, past any parity bit
   wire [3:0] rxStopIdx = dataBits + 4'h1 + {3'h0, lcr[3]};
   wire rxDone = rxBusy & baudTick & rxOvs == 4'h7 & rxBit == rxStopIdx;
   wire txStart = !txBusy & !txEmpty & baudTick;
   wire txDone = txBusy & baudTick & txOvs == 4'hf & txBit == frameLen - 4'h1;
   // Event pulses in status bit order
   wire [3:0] istSet;
   assign istSet[`ISL_IST_RX] = rxDone;
   assign istSet[`ISL_IST_TXE] = txDone & txEmpty;
   assign istSet[`ISL_IST_OVR] = rxDone & rxFull;
   assign istSet[`ISL_IST_FERR] = rxDone & ~rxSync;
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         preCnt <= 2'h0;
         divCnt <= 16'h0000;
         baudTick <= 1'b0;
      end
      else
      begin
         baudTick <= 1'b0;
         if (refClkTick)
            preCnt <= preCnt + 2'h1;
         if (preTick)
         begin
            // Rate is prescaled reference over divisor, divisor zero treated as one
            if (divCnt + 16'h1 >= divisor)
            begin
               divCnt <= 16'h0000;
               baudTick <= 1'b1;
            end
            else
               divCnt <= divCnt + 16'h1;
         end
      end
   end
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         txBusy <= 1'b0;
         txOvs <= 4'h0;
         txBit <= 4'h0;
         txShift <= 10'h3ff;
         txData <= 1'b1;
         txRp <= 8'h00;
         autoEn <= 1'b0;
      end
      else
      begin
         if (txStart)
         begin
            txBusy <= 1'b1;
            autoEn <= 1'b1;
            txOvs <= 4'h0;
            txBit <= 4'h0;
            txShift <= {1'b1, parityBit, txMem[txRp[6:0]]};
            txData <= 1'b0;
            txRp <= txRp + 8'h01;
         end
         else if (txBusy & baudTick)
         begin
            txOvs <= txOvs + 4'h1;
            if (txOvs == 4'hf)
            begin
               txBit <= txBit + 4'h1;
               if (txDone)
               begin
                  txBusy <= 1'b0;
                  txData <= 1'b1;
                  if (txEmpty)
                     autoEn <= 1'b0;
               end
               else if (txBit < dataBits)
               begin
                  txData <= txShift[0];
                  txShift <= {1'b1, txShift[9:1]};
               end
               else if (txBit == dataBits && lcr[3])
                  txData <= lcr[5] ? ~lcr[4] : txShift[padBits];
               else
                  txData <= 1'b1;
            end
         end
         else if (!txBusy & txEmpty)
            autoEn <= 1'b0;
      end
   end
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         rxBusy <= 1'b0;
         rxOvs <= 4'h0;
         rxBit <= 4'h0;
         rxShift <= 8'h00;
         rxSync <= 1'b1;
         rxWp <= 8'h00;
      end
      else
      begin
         rxSync <= rxIn;
         if (!rxBusy & baudTick & !rxSync)
         begin
            rxBusy <= 1'b1;
            rxOvs <= 4'h0;
            rxBit <= 4'h0;
         end
         else if (rxBusy & baudTick)
         begin
            rxOvs <= rxOvs + 4'h1;
            // Sample at the eighth tick, mid-bit
            if (rxOvs == 4'h7)
            begin
               rxBit <= rxBit + 4'h1;
               if (rxBit == 4'h0 && rxSync)
                  rxBusy <= 1'b0;
               else if (rxBit != 4'h0 && rxBit <= dataBits)
                  rxShift <= {rxSync, rxShift[7:1]};
               if (rxDone)
               begin
                  rxBusy <= 1'b0;
                  if (!rxFull)
                  begin
                     rxMem[rxWp[6:0]] <= rxShift >> padBits;
                     rxWp <= rxWp + 8'h01;
                  end
               end
            end
         end
      end
   end
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         ier <= 8'h00;
         lcr <= `ISL_LCR_RST;
         divisor <= `ISL_DIV_RST;
         mcr <= 8'h00;
         imask <= 4'h0;
         istat <= 4'h0;
         txWp <= 8'h00;
         rxRp <= 8'h00;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         // Registered ack: one wait state, and a held request is not taken twice
         wb_ack_o <= wbReq;
         if (wbWr)
         begin
            case (regIdx)
               `ISL_ADR_RBR:
                  if (dlab)
                     divisor[7:0] <= wb_dat_i[7:0];
                  else if (!txFull)
                  begin
                     txMem[txWp[6:0]] <= wb_dat_i[7:0];
                     txWp <= txWp + 8'h01;
                  end
               `ISL_ADR_IER: ier <= wb_dat_i[7:0];
               `ISL_ADR_LCR: lcr <= wb_dat_i[7:0];
               `ISL_ADR_DLL: divisor[7:0] <= wb_dat_i[7:0];
               `ISL_ADR_DLM: divisor[15:8] <= wb_dat_i[7:0];
               `ISL_ADR_STAT: mcr <= wb_dat_i[7:0];
               `ISL_ADR_IMSK: imask <= wb_dat_i[3:0];
               default: ;
            endcase
         end
         if (wbRd && regIdx == `ISL_ADR_RBR && !dlab && !rxEmpty)
            rxRp <= rxRp + 8'h01;
         // Set wins over write-one-to-clear
         istat <= (istat & ~((wbWr && regIdx == `ISL_ADR_IST) ? wb_dat_i[3:0] : 4'h0))
            | istSet;
         if (wbRd)
         begin
            case (regIdx)
               `ISL_ADR_RBR: wb_dat_o <= {24'h0, dlab ? divisor[7:0] : rxMem[rxRp[6:0]]};
               `ISL_ADR_IER: wb_dat_o <= {24'h0, ier};
               `ISL_ADR_LCR: wb_dat_o <= {24'h0, lcr};
               `ISL_ADR_DLL: wb_dat_o <= {24'h0, divisor[7:0]};
               `ISL_ADR_DLM: wb_dat_o <= {24'h0, divisor[15:8]};
               `ISL_ADR_STAT: wb_dat_o <= {16'h0, rxWp - rxRp, ~ctsLine, driverOn,
                  txBusy, rxBusy, txFull, txEmpty, rxFull, ~rxEmpty};
               `ISL_ADR_IST: wb_dat_o <= {28'h0, istat};
               `ISL_ADR_IMSK: wb_dat_o <= {28'h0, imask};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
   assign irq = |(istat & imask);
endmodule // isl_serial_line
`default_nettype wire

/* File: dv/isl_line_partner.sv */
// Remote station: silent, so the pair shows device bits or bias high
`timescale 1ns/10ps
`default_nettype none
module isl_line_partner (
   input wire logic txData,
   input wire logic txOe_b,
   output logic rxLine
);
   assign rxLine = txOe_b ? 1'b1 : txData;
endmodule // isl_line_partner
`default_nettype wire

/* File: dv/isl_serial_line_properties.sv */
// Port assertions for the serial line block
`timescale 1ns/10ps
`default_nettype none
module isl_serial_line_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] interface_select_switch,
   input wire logic auto_driver_enable_sel,
   input wire logic rts_driver_enable_sel,
   input wire logic txData,
   input wire logic txOe_b,
   input wire logic rtsLine,
   input wire logic [1:0] lineMode
);
   wire m485 = interface_select_switch == 2'h2;
   wire autoOnly = auto_driver_enable_sel && !rts_driver_enable_sel;
   wire rtsOnly = rts_driver_enable_sel && !auto_driver_enable_sel;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence wbTake;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   ack_answer_a: assert property (wbTake |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   mode_follow_a: assert property (lineMode == interface_select_switch)
      else $error("mode differs");
   point_drive_a: assert property (!m485 |-> !txOe_b)
      else $error("driver off");
   rts_gate_a: assert property (m485 && rtsOnly |-> txOe_b == rtsLine)
      else $error("driver ignores rts");
   one_source_a: assert property (m485 && (autoOnly == rtsOnly) |-> txOe_b)
      else $error("driver on without one source");
   auto_start_a: assert property (m485 && autoOnly && $fell(txData) |-> !txOe_b)
      else $error("start bit undriven");
   auto_idle_a: assert property (m485 && autoOnly && txOe_b |-> txData)
      else $error("data while released");
endmodule // isl_serial_line_chk
bind isl_serial_line isl_serial_line_chk u_chk (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .interface_select_switch, .auto_driver_enable_sel, .rts_driver_enable_sel,
   .txData, .txOe_b, .rtsLine, .lineMode);
`default_nettype wire

/* File: dv/testbench.sv */
// Bench: bus tasks, bit timing, echo and driver source checks
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk_sys;
   logic rst_b = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [1:0] md = 2'h1;
   logic au = 1'b0;
   logic rtsSel = 1'b0;
   logic qs = 1'b1;
   logic us = 1'b0;
   logic noEchoSel = 1'b0;
   logic refClkTick = 1'b0;
   logic [31:0] wb_dat_o, q;
   logic [1:0] lineMode;
   logic wb_ack_o, irq, rxLine, txData, txOe_b, rtsLine;
   int checked = 0;
   int n_mismatch = 0;
   isl_serial_line u_isl_serial_line (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
      .interface_select_switch(md), .auto_driver_enable_sel(au), .rts_driver_enable_sel(rtsSel),
      .prescale_quarter_sel(qs), .prescale_unity_sel(us), .noEchoSel, .refClkTick, .rxLine,
      .ctsLine(1'b0), .txData, .txOe_b, .rtsLine, .lineMode);
   isl_line_partner u_isl_line_partner (.txData, .txOe_b, .rxLine);
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Reference tick every other cycle: unity bit is 32 cycles, quarter 128
   always @(posedge clk_sys) refClkTick <= ~refClkTick;
   task automatic summarize;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cb(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (wb_ack_o !== 1'b1)
         n_mismatch++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      cmp(q, e);
   endtask
   // Sends 0x01, so the low time after the fall is the start bit alone
   task automatic frame(input int bt);
      int n;
      wb(1'b1, 5'h00, 32'h1);
      n = 0;
      while (txData !== 1'b0 && n < 900)
      begin
         @(posedge clk_sys);
         n++;
      end
      n = 0;
      while (txData === 1'b0 && n < 900)
      begin
         @(posedge clk_sys);
         n++;
      end
      cmp(n, bt);
      repeat (10 * bt) @(posedge clk_sys);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      summarize;
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      cmp({30'h0, lineMode}, 32'h1);
      cb(txOe_b, 1'b0);
      rd(5'h08, 32'h3);
      rd(5'h0c, 32'h30);
      $display("reset test ended");
      wb(1'b1, 5'h0c, 32'h1);
      wb(1'b1, 5'h1c, 32'h1);
      md <= 2'h2;
      au <= 1'b1;
      frame(128);
      qs <= 1'b0;
      us <= 1'b1;
      frame(32);
      cb(txOe_b, 1'b1);
      cb(irq, 1'b1);
      rd(5'h00, 32'h1);
      rd(5'h00, 32'h1);
      wb(1'b1, 5'h18, 32'h3);
      rd(5'h18, 32'h0);
      cb(irq, 1'b0);
      // Seven bits with even parity: the echo must come back right-justified
      wb(1'b1, 5'h08, 32'h1a);
      frame(32);
      rd(5'h00, 32'h1);
      wb(1'b1, 5'h08, 32'h3);
      $display("rate and echo test ended");
      noEchoSel <= 1'b1;
      frame(32);
      wb(1'b0, 5'h14, 32'h0);
      cb(q[0], 1'b0);
      // Unity prescale with four times the divisor matches the standard rate
      wb(1'b1, 5'h0c, 32'h4);
      frame(128);
      $display("no echo test ended");
      au <= 1'b0;
      rtsSel <= 1'b1;
      wb(1'b1, 5'h14, 32'h2);
      cb(txOe_b, 1'b0);
      cb(rtsLine, 1'b0);
      wb(1'b1, 5'h14, 32'h0);
      cb(txOe_b, 1'b1);
      au <= 1'b1;
      wb(1'b1, 5'h14, 32'h2);
      cb(txOe_b, 1'b1);
      md <= 2'h0;
      @(posedge clk_sys);
      cb(txOe_b, 1'b0);
      $display("driver source test ended");
      summarize;
   end
endmodule // testbench
`default_nettype wire
